// [src/stm_pkg.sv]
// package: register map, field layout and constants of the sixteen-bit timer
package stm_pkg;

  // ************************************************************
  // register offsets (byte addresses, chosen)
  // ************************************************************
  localparam logic [4:0] STM_OFF_CTRL = 5'h00;
  localparam logic [4:0] STM_OFF_LOW = 5'h04;
  localparam logic [4:0] STM_OFF_HIGH = 5'h08;
  localparam logic [4:0] STM_OFF_FLAG = 5'h0C;
  localparam logic [4:0] STM_OFF_IEN = 5'h10;

  // ************************************************************
  // control register fields
  // ************************************************************
  localparam int STM_B_RUN = 0;
  localparam int STM_B_SRC = 1;
  localparam int STM_B_SYNC = 2;
  localparam int STM_B_OSCEN = 3;
  localparam int STM_B_PS_LO = 4;
  localparam int STM_B_PS_HI = 5;
  localparam int STM_B_STAT = 6;
  localparam int STM_B_WIDE = 7;
  localparam int STM_B_FLAG = 0;
  localparam logic [7:0] STM_CTRL_RST = 8'h00;
  localparam logic [7:0] STM_CTRL_WMASK = 8'hBF;
  localparam logic [15:0] STM_CNT_RST = 16'h0000;
  localparam logic [15:0] STM_CNT_ONES = 16'hFFFF;

  // ************************************************************
  // bus answers
  // ************************************************************
  localparam logic [1:0] STM_RESP_OKAY = 2'h0;
  localparam logic [1:0] STM_RESP_SLVERR = 2'h2;

  // decoded control word
  typedef struct packed {
    logic wide;
    logic [1:0] ps;
    logic oscen;
    logic sync_bypass;
    logic src_ext;
    logic run;
  } stm_ctrl_s;

  // write channel state: gray along idle -> wait for bready
  typedef enum logic [1:0] {
    STM_W_IDLE = 2'b00,
    STM_W_RESP = 2'b01
  } stm_wstate_e;

endpackage

// [src/stm_prescaler.sv]
// prescaler: divides count ticks by 1, 2, 4 or 8
`timescale 1ns/1ps
module stm_prescaler
  import stm_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // control
  input wire logic [1:0] ps_sel,
  input wire logic clear,
  input wire logic tick_in,
  // result
  output logic tick_out
);

  logic [2:0] div_r;
  logic [2:0] div_mask;

  // prescale ratio select
  // 00 -> 1:1, 01 -> 1:2, 10 -> 1:4, 11 -> 1:8
  always_comb
  begin
    case (ps_sel)
      2'h0: div_mask = 3'h0;
      2'h1: div_mask = 3'h1;
      2'h2: div_mask = 3'h3;
      default: div_mask = 3'h7;
    endcase
  end

  assign tick_out = tick_in && ((div_r & div_mask) == div_mask);

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      div_r <= 3'h0;
    else if (clear)
      div_r <= 3'h0;
    else if (tick_in)
      div_r <= (div_r & div_mask) == div_mask ? 3'h0 : div_r + 3'h1;
  end

endmodule

// [src/stm_timer.sv]
// sixteen-bit timer with secondary oscillator control and AXI4-Lite registers
`timescale 1ns/1ps

module stm_timer
  import stm_pkg::*;
#(
  parameter int QUARTER_DIV = 4
)
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // axi4-lite write address and data
  input wire logic [4:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [4:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // count sources and system status
  input wire logic ext_clk_in,
  input wire logic special_event_trig,
  input wire logic osc_is_sys_clk,
  // oscillator control and events
  output logic osc_amp_enable,
  output logic overflow_pulse,
  output logic overflow_irq
);

  // ************************************************************
  // registers
  // ************************************************************
  logic [7:0] ctrl_r;
  stm_ctrl_s ctl;
  logic [15:0] count_r;
  logic [7:0] high_buf_r;
  logic flag_r;
  logic ien_r;
  logic osc_stat_r;
  logic ext_s1_r;
  logic ext_s2_r;
  logic ext_prev_r;
  logic [1:0] q_cnt_r;
  logic int_tick;
  logic ext_edge;
  logic src_tick;
  logic ps_tick;
  logic ovf;

  // fields picked one by one: bit 6 is status and has no slot in the control word
  assign ctl = stm_ctrl_s'({ctrl_r[STM_B_WIDE], ctrl_r[STM_B_PS_HI:STM_B_PS_LO], ctrl_r[STM_B_OSCEN],
    ctrl_r[STM_B_SYNC], ctrl_r[STM_B_SRC], ctrl_r[STM_B_RUN]});

  // ************************************************************
  // write channel: address and data taken in either order
  // ************************************************************
  stm_wstate_e wstate_r;
  logic aw_held_r;
  logic w_held_r;
  logic [4:0] awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;
  logic wr_fire;
  logic [4:0] wr_addr;
  logic [7:0] wr_byte;
  logic wr_ok;

  assign s_axi_awready = (wstate_r == STM_W_IDLE) && !aw_held_r;
  assign s_axi_wready = (wstate_r == STM_W_IDLE) && !w_held_r;
  assign wr_fire = (wstate_r == STM_W_IDLE) && (aw_held_r || s_axi_awvalid) && (w_held_r || s_axi_wvalid);
  assign wr_addr = aw_held_r ? awaddr_r : s_axi_awaddr;
  assign wr_byte = w_held_r ? wdata_r[7:0] : s_axi_wdata[7:0];
  assign wr_ok = wr_fire && (w_held_r ? wstrb_r[0] : s_axi_wstrb[0]);

  function automatic logic addr_mapped(input logic [4:0] a);
    addr_mapped = (a == STM_OFF_CTRL) || (a == STM_OFF_LOW) || (a == STM_OFF_HIGH) || (a == STM_OFF_FLAG)
      || (a == STM_OFF_IEN);
  endfunction

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wstate_r <= STM_W_IDLE;
      aw_held_r <= 1'b0;
      w_held_r <= 1'b0;
      awaddr_r <= 5'h00;
      wdata_r <= 32'h00000000;
      wstrb_r <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= STM_RESP_OKAY;
    end
    else
    begin
      case (wstate_r)
        STM_W_IDLE:
        begin
          if (wr_fire)
          begin
            aw_held_r <= 1'b0;
            w_held_r <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= addr_mapped(wr_addr) ? STM_RESP_OKAY : STM_RESP_SLVERR;
            wstate_r <= STM_W_RESP;
          end
          else
          begin
            if (s_axi_awvalid && !aw_held_r)
            begin
              aw_held_r <= 1'b1;
              awaddr_r <= s_axi_awaddr;
            end
            if (s_axi_wvalid && !w_held_r)
            begin
              w_held_r <= 1'b1;
              wdata_r <= s_axi_wdata;
              wstrb_r <= s_axi_wstrb;
            end
          end
        end
        STM_W_RESP:
        begin
          if (s_axi_bready)
          begin
            s_axi_bvalid <= 1'b0;
            wstate_r <= STM_W_IDLE;
          end
        end
        default: wstate_r <= STM_W_IDLE;
      endcase
    end
  end

  logic wr_ctrl;
  logic wr_low;
  logic wr_high;
  assign wr_ctrl = wr_ok && (wr_addr == STM_OFF_CTRL);
  assign wr_low = wr_ok && (wr_addr == STM_OFF_LOW);
  assign wr_high = wr_ok && (wr_addr == STM_OFF_HIGH);

  // ************************************************************
  // read channel
  // ************************************************************
  logic rd_fire;
  logic rd_low;
  assign s_axi_arready = !s_axi_rvalid;
  assign rd_fire = s_axi_arvalid && s_axi_arready;
  assign rd_low = rd_fire && (s_axi_araddr == STM_OFF_LOW);

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= STM_RESP_OKAY;
    end
    else if (rd_fire)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= addr_mapped(s_axi_araddr) ? STM_RESP_OKAY : STM_RESP_SLVERR;
      case (s_axi_araddr)
        STM_OFF_CTRL: s_axi_rdata <= {24'h000000, ctl.wide, osc_stat_r, ctl.ps, ctl.oscen, ctl.sync_bypass,
          ctl.src_ext, ctl.run};
        STM_OFF_LOW: s_axi_rdata <= {24'h000000, count_r[7:0]};
        STM_OFF_HIGH: s_axi_rdata <= {24'h000000, ctl.wide ? high_buf_r : count_r[15:8]};
        STM_OFF_FLAG: s_axi_rdata <= {31'h00000000, flag_r};
        STM_OFF_IEN: s_axi_rdata <= {31'h00000000, ien_r};
        default: s_axi_rdata <= 32'h00000000;
      endcase
    end
    else if (s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

  // ************************************************************
  // control and status
  // ************************************************************
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      ctrl_r <= STM_CTRL_RST;
    else if (wr_ctrl)
      ctrl_r <= wr_byte & STM_CTRL_WMASK;
  end

  // status follows the clock monitor's actual source selection
  // system clock source reported to software
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      osc_stat_r <= 1'b0;
    else
      osc_stat_r <= osc_is_sys_clk;
  end

  // amplifier and feedback off when cleared
  assign osc_amp_enable = ctl.oscen;

  // ************************************************************
  // count sources
  // ************************************************************
  // internal clock is one quarter of ref_clk
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      q_cnt_r <= 2'h0;
    else
      q_cnt_r <= (q_cnt_r == 2'(QUARTER_DIV - 1)) ? 2'h0 : q_cnt_r + 2'h1;
  end
  assign int_tick = (q_cnt_r == 2'(QUARTER_DIV - 1));

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ext_s1_r <= 1'b0;
      ext_s2_r <= 1'b0;
      ext_prev_r <= 1'b0;
    end
    else
    begin
      ext_s1_r <= ext_clk_in;
      ext_s2_r <= ext_s1_r;
      ext_prev_r <= ctl.sync_bypass ? ext_clk_in : ext_s2_r;
    end
  end

  // bypass samples the raw pin; otherwise the two-stage synchronised copy
  // inputs count as synchronous to ref_clk, so bypass only drops the two-cycle delay
  assign ext_edge = ctl.sync_bypass ? (ext_clk_in && !ext_prev_r) : (ext_s2_r && !ext_prev_r);

  // internal source ignores the sync bit
  // rising edge of the external pin
  assign src_tick = ctl.src_ext ? ext_edge : int_tick;

  // stopped counter feeds no ticks into the prescaler
  // low write restarts the prescale period
  stm_prescaler u_prescaler (
    .ref_clk (ref_clk),
    .rst_n (rst_n),
    .ps_sel (ctl.ps),
    .clear (wr_low),
    .tick_in (src_tick && ctl.run),
    .tick_out (ps_tick)
  );

  // ************************************************************
  // counter
  // ************************************************************
  // wrap only by counting, never by write; a trigger on the same tick does not suppress it
  assign ovf = ps_tick && (count_r == STM_CNT_ONES) && !wr_low && !(wr_high && !ctl.wide);

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      count_r <= STM_CNT_RST;
    else if (wr_low)
    begin
      // high byte loads from buffer in wide mode
      count_r[7:0] <= wr_byte;
      if (ctl.wide)
        count_r[15:8] <= high_buf_r;
    end
    // a wide-mode buffer write must not cost the counter a tick or a trigger
    else if (wr_high && !ctl.wide)
      count_r[15:8] <= wr_byte;
    else if (special_event_trig)
      count_r <= STM_CNT_RST;
    // counts only while run is set
    else if (ps_tick)
      count_r <= count_r + 16'h0001;
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      high_buf_r <= 8'h00;
    // buffer write leaves the prescaler alone
    else if (wr_high && ctl.wide)
      high_buf_r <= wr_byte;
    else if (rd_low && ctl.wide)
      high_buf_r <= count_r[15:8];
  end

  // ************************************************************
  // overflow flag and enable
  // ************************************************************
  // overflow sets, set wins over a clear-by-zero write
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      flag_r <= 1'b0;
    else if (ovf)
      flag_r <= 1'b1;
    else if (wr_ok && (wr_addr == STM_OFF_FLAG))
      flag_r <= wr_byte[STM_B_FLAG];
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      ien_r <= 1'b0;
    else if (wr_ok && (wr_addr == STM_OFF_IEN))
      ien_r <= wr_byte[STM_B_FLAG];
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      overflow_pulse <= 1'b0;
    else
      overflow_pulse <= ovf;
  end

  // overflow requests an interrupt when enabled
  assign overflow_irq = flag_r && ien_r;

endmodule

// [verification/stm_timer_asserts.sv]
// checker: bus handshake and event properties at the timer ports
`timescale 1ns/1ps
module stm_timer_asserts
  import stm_pkg::*;
#(
  parameter int QUARTER_DIV = 4
)
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // register bus
  input wire logic [4:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // events
  input wire logic osc_amp_enable,
  input wire logic overflow_pulse
);
  default clocking @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);

  // *****
  // properties
  // *****
  a_write_answer:
  assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> s_axi_bvalid)
    else $error("write gave no response");
  a_write_gate:
  assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while response pending");
  a_resp_okay:
  assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    && s_axi_awaddr == STM_OFF_LOW |=> s_axi_bresp == STM_RESP_OKAY)
    else $error("mapped write not answered okay");
  a_read_answer:
  assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read gave no data");
  a_read_gate:
  assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while data pending");
  a_rvalid_drop:
  assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read data repeated");
  a_upper_zero:
  assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
    else $error("upper read bits not zero");
  a_osc_follows:
  assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && s_axi_wstrb[0]
    && s_axi_awaddr == STM_OFF_CTRL |=> osc_amp_enable == $past(s_axi_wdata[STM_B_OSCEN]))
    else $error("oscillator enable not from control");
  a_ovf_single:
  assert property (overflow_pulse |=> !overflow_pulse)
    else $error("overflow pulse too long");
endmodule

bind stm_timer stm_timer_asserts #(.QUARTER_DIV(QUARTER_DIV)) chk_u (
  .ref_clk(ref_clk), .rst_n(rst_n), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .osc_amp_enable(osc_amp_enable), .overflow_pulse(overflow_pulse));

// [verification/stm_ext_src.sv]
// partner: external count clock pin and system clock status source
`timescale 1ns/1ps
module stm_ext_src
(
  // clock
  input wire logic ref_clk,
  // pins toward the timer
  output logic ext_clk_in,
  output logic osc_is_sys_clk
);
  initial
  begin
    ext_clk_in = 1'b0;
    osc_is_sys_clk = 1'b0;
  end
  // rising edges counted
  // slow edges so the synchroniser sees every level; pin rests low between bursts
  task pulses(input int n);
    repeat (n)
    begin
      repeat (5) @(posedge ref_clk);
      ext_clk_in <= 1'b1;
      repeat (5) @(posedge ref_clk);
      ext_clk_in <= 1'b0;
    end
    repeat (5) @(posedge ref_clk);
  endtask
  task set_sys(input logic b);
    @(posedge ref_clk);
    osc_is_sys_clk <= b;
    repeat (3) @(posedge ref_clk);
  endtask
endmodule

// [verification/stm_timer_bench.sv]
// testbench: register level tests of the sixteen-bit timer
`timescale 1ns/1ps
module stm_timer_bench
  import stm_pkg::*;
;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [4:0] awa = 5'h00;
  logic [4:0] ara = 5'h00;
  logic [31:0] wdt = 32'h00000000;
  logic awv = 1'b0, wv = 1'b0, br = 1'b0, arv = 1'b0, rr = 1'b0, trg = 1'b0;
  logic awr, wrd, bv, arr, rv, ext, sys, amp, opl, irq;
  logic [1:0] brs, rrs;
  logic [31:0] rdt, v;
  int err_total = 0;
  int n_tests = 0;
  int n_ovf = 0;

  always #20 ref_clk = ~ref_clk;

  // counts overflow pulses as seen at each edge
  always @(posedge ref_clk)
  begin
    if (opl === 1'b1)
      n_ovf++;
  end

  stm_timer dut_u (.ref_clk(ref_clk), .rst_n(rst_n), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
    .s_axi_awready(awr), .s_axi_wdata(wdt), .s_axi_wstrb(4'h1), .s_axi_wvalid(wv), .s_axi_wready(wrd),
    .s_axi_bresp(brs), .s_axi_bvalid(bv), .s_axi_bready(br), .s_axi_araddr(ara), .s_axi_arvalid(arv),
    .s_axi_arready(arr), .s_axi_rdata(rdt), .s_axi_rresp(rrs), .s_axi_rvalid(rv), .s_axi_rready(rr),
    .ext_clk_in(ext), .special_event_trig(trg), .osc_is_sys_clk(sys), .osc_amp_enable(amp),
    .overflow_pulse(opl), .overflow_irq(irq));
  stm_ext_src ext_u (.ref_clk(ref_clk), .ext_clk_in(ext), .osc_is_sys_clk(sys));

  // *****
  // bus tasks
  // *****
  task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    n_tests++;
    if (s !== e)
    begin
      err_total++;
      $display("wrong value %s expected %h seen %h", nm, e, s);
    end
  endtask
  // optional trigger pulse lands on the very edge the write executes
  task wr(input logic [4:0] a, input logic [7:0] d, input logic t = 1'b0);
    @(posedge ref_clk);
    awa <= a;
    wdt <= {24'h000000, d};
    awv <= 1'b1;
    wv <= 1'b1;
    br <= 1'b1;
    trg <= t;
    do
    begin
      @(posedge ref_clk);
      trg <= 1'b0;
      if (awr) awv <= 1'b0;
      if (wrd) wv <= 1'b0;
      if (bv)
      begin
        br <= 1'b0;
        v = {30'h00000000, brs};
      end
    end while (awv || wv || br);
  endtask
  task rd(input logic [4:0] a);
    @(posedge ref_clk);
    ara <= a;
    arv <= 1'b1;
    rr <= 1'b1;
    do
    begin
      @(posedge ref_clk);
      if (arr) arv <= 1'b0;
      if (rv)
      begin
        rr <= 1'b0;
        v = rdt;
      end
    end while (arv || rr);
  endtask
  task rc(input logic [4:0] a, input logic [7:0] e, input string nm);
    rd(a);
    chk(nm, v, {24'h000000, e});
  endtask
  task endt(input string nm);
    $display("test %s done", nm);
  endtask
  task end_sim;
    $display("checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  initial
  begin
    repeat (30000) @(posedge ref_clk);
    err_total++;
    end_sim;
  end

  // *****
  // tests
  // *****
  initial
  begin
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'b1;
    rc(STM_OFF_CTRL, 8'h00, "ctrl reset");
    rc(STM_OFF_LOW, 8'h00, "low reset");
    wr(5'h14, 8'h01);
    chk("unmapped bresp", v, {30'h00000000, STM_RESP_SLVERR});
    wr(STM_OFF_CTRL, 8'hFF);
    chk("amp on", {31'h00000000, amp}, 32'h00000001);
    rc(STM_OFF_CTRL, STM_CTRL_WMASK, "ctrl status low");
    ext_u.set_sys(1'b1);
    rc(STM_OFF_CTRL, 8'hFF, "ctrl status high");
    ext_u.set_sys(1'b0);
    wr(STM_OFF_CTRL, 8'h00);
    chk("amp off", {31'h00000000, amp}, 32'h00000000);
    endt("control");
    wr(STM_OFF_LOW, 8'h34);
    wr(STM_OFF_HIGH, 8'h12);
    repeat (20) @(posedge ref_clk);
    rc(STM_OFF_LOW, 8'h34, "held low");
    rc(STM_OFF_HIGH, 8'h12, "held high");
    @(posedge ref_clk);
    trg <= 1'b1;
    @(posedge ref_clk);
    trg <= 1'b0;
    rc(STM_OFF_LOW, 8'h00, "trig low");
    rc(STM_OFF_HIGH, 8'h00, "trig high");
    rc(STM_OFF_FLAG, 8'h00, "trig flag");
    wr(STM_OFF_LOW, 8'h77, 1'b1);
    rc(STM_OFF_LOW, 8'h77, "write beats trig");
    endt("trigger");
    // internal source with the sync bit set, which must be ignored
    for (int p = 0; p < 4; p++)
    begin
      wr(STM_OFF_HIGH, 8'h00);
      wr(STM_OFF_LOW, 8'h00);
      wr(STM_OFF_CTRL, {2'b00, p[1:0], 4'b0101});
      repeat ((256 << p) - 4) @(posedge ref_clk);
      wr(STM_OFF_CTRL, 8'h00);
      rd(STM_OFF_LOW);
      chk("prescaled count", {31'h00000000, v >= 63 && v <= 65}, 32'h00000001);
    end
    wr(STM_OFF_CTRL, 8'h31);
    repeat (4)
    begin
      wr(STM_OFF_LOW, 8'h00);
      repeat (20) @(posedge ref_clk);
    end
    wr(STM_OFF_CTRL, 8'h00);
    rc(STM_OFF_LOW, 8'h00, "prescaler cleared");
    endt("prescale");
    wr(STM_OFF_IEN, 8'h01);
    wr(STM_OFF_HIGH, 8'hFF);
    wr(STM_OFF_LOW, 8'hFE);
    wr(STM_OFF_CTRL, 8'h01);
    repeat (20) @(posedge ref_clk);
    wr(STM_OFF_CTRL, 8'h00);
    rc(STM_OFF_FLAG, 8'h01, "overflow flag");
    rc(STM_OFF_HIGH, 8'h00, "wrapped high");
    chk("irq on", {31'h00000000, irq}, 32'h00000001);
    chk("overflow pulses", n_ovf, 32'h00000001);
    wr(STM_OFF_IEN, 8'h00);
    chk("irq masked", {31'h00000000, irq}, 32'h00000000);
    wr(STM_OFF_FLAG, 8'h00);
    rc(STM_OFF_FLAG, 8'h00, "flag cleared");
    endt("overflow");
    wr(STM_OFF_CTRL, 8'h80);
    wr(STM_OFF_HIGH, 8'hAB);
    wr(STM_OFF_LOW, 8'hCD);
    rc(STM_OFF_LOW, 8'hCD, "wide low");
    rc(STM_OFF_HIGH, 8'hAB, "wide high");
    wr(STM_OFF_HIGH, 8'h55);
    rc(STM_OFF_LOW, 8'hCD, "wide low again");
    rc(STM_OFF_HIGH, 8'hAB, "buffer only");
    wr(STM_OFF_CTRL, 8'h00);
    endt("wide");
    for (int s = 0; s < 2; s++)
    begin
      wr(STM_OFF_LOW, 8'h00);
      wr(STM_OFF_HIGH, 8'h00);
      wr(STM_OFF_CTRL, {5'b00000, s[0], 2'b11});
      ext_u.pulses(9);
      wr(STM_OFF_CTRL, 8'h00);
      rc(STM_OFF_LOW, 8'h09, "external count");
    end
    endt("external");
    end_sim;
  end
endmodule
